// >>> core/collision_stretch.sv
`timescale 1ns/1ps
`include "strap_led_cfg.svh"

module collision_stretch
    import strap_led_pkg::*;
#(
    parameter int unsigned STRETCH_CYCLES = `COL_STRETCH_CYCLES
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic collision,
    output logic stretched
);

    logic [23:0] count;
    logic [23:0] next_count;

    // ----------------------------------------
    // Retrigger on every collision
    // ----------------------------------------
    always_comb
    begin
        next_count = count;
        if (collision)
        begin
            next_count = 24'(STRETCH_CYCLES); // RL5
        end
        else if (count != 24'h000000)
        begin
            next_count = count - 24'h000001;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            count <= `STRETCH_RESET;
        end
        else
        begin
            count <= next_count;
        end
    end

    // Shows while collisions persist and for the hold time after the last one
    assign stretched = collision || (count != 24'h000000); // RL4 RL5

endmodule : collision_stretch

// >>> core/strap_led.sv
// What this block does
// RL1 - During power-on or hardware reset the five pins are inputs, sampled when reset ends.
// RL2 - A low sampled pin gives address bit zero and a high one gives one.
// RL3 - Collision pin is address bit 1, link bit 2, transmit bit 3 and receive bit 4.
// RL4 - After reset the collision pin is asserted while collisions are seen.
// RL5 - Each collision holds the collision output asserted for about 70 ms.
// RL6 - After reset the link pin is asserted while a valid link exists.
// RL7 - After reset the transmit pin is asserted while transmit activity is present.
// RL8 - After reset the receive pin is asserted while receive activity is present.
// RL9 - The asserted output level is the inverse of the level sampled at reset.
// RL10 - A software reset neither resamples the pins nor turns them back to inputs.
// RL11 - The activity pin gives address bit 0 and then shows transmit or receive activity.
// RL12 - The sampled address is held until the next hardware reset and offered for matching.
`timescale 1ns/1ps
`include "strap_led_cfg.svh"

module strap_led
    import strap_led_pkg::*;
#(
    parameter int unsigned STRETCH_CYCLES = `COL_STRETCH_CYCLES
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic soft_reset,
    input wire link_status_s status,
    input wire logic addr0_activity_led_i,
    output logic addr0_activity_led_o,
    output logic addr0_activity_led_oe_n,
    input wire logic addr1_collision_led_i,
    output logic addr1_collision_led_o,
    output logic addr1_collision_led_oe_n,
    input wire logic addr2_link_led_i,
    output logic addr2_link_led_o,
    output logic addr2_link_led_oe_n,
    input wire logic addr3_tx_led_i,
    output logic addr3_tx_led_o,
    output logic addr3_tx_led_oe_n,
    input wire logic addr4_rx_led_i,
    output logic addr4_rx_led_o,
    output logic addr4_rx_led_oe_n,
    output phy_addr_t phy_addr,
    output logic phy_addr_valid
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    pin_mode_e mode;
    pin_mode_e next_mode;
    phy_addr_t addr;
    phy_addr_t next_addr;
    logic [4:0] pins_in;
    logic [4:0] next_led_state;
    pin_drive_s drive;
    pin_drive_s next_drive;
    logic col_stretched;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Address bit N is taken from pin N
    function automatic phy_addr_t strap_addr(input logic [4:0] pins);
        phy_addr_t a;
        a = `ADDR_RESET;
        a[0] = pins[`PIN_ACTIVITY]; // RL11
        a[1] = pins[`PIN_COLLISION]; // RL3
        a[2] = pins[`PIN_LINK]; // RL3
        a[3] = pins[`PIN_TX]; // RL3
        a[4] = pins[`PIN_RX]; // RL3
        return a;
    endfunction : strap_addr

    // Collision comes in already stretched, the other pins follow status directly
    function automatic logic [4:0] status_leds(input link_status_s s, input logic col);
        logic [4:0] leds;
        leds = 5'h00;
        leds[`PIN_ACTIVITY] = s.tx_active || s.rx_active; // RL11
        leds[`PIN_COLLISION] = col; // RL4 RL5
        leds[`PIN_LINK] = s.link; // RL6
        leds[`PIN_TX] = s.tx_active; // RL7
        leds[`PIN_RX] = s.rx_active; // RL8
        return leds;
    endfunction : status_leds

    // Asserted level is the opposite of the strap, lighting the series LED
    function automatic logic [4:0] pin_level(input logic [4:0] leds, input phy_addr_t strap);
        return leds ^ strap; // RL9
    endfunction : pin_level

    // Pins stay released until the address is in the latch, then are driven for good
    function automatic logic [4:0] pin_enable_n(input pin_mode_e m);
        return (m == ST_LED) ? 5'h00 : 5'h1f; // RL1 RL10
    endfunction : pin_enable_n

    // ----------------------------------------
    // Strap pins
    // ----------------------------------------
    assign pins_in[`PIN_ACTIVITY] = addr0_activity_led_i; // RL11
    assign pins_in[`PIN_COLLISION] = addr1_collision_led_i; // RL3
    assign pins_in[`PIN_LINK] = addr2_link_led_i; // RL3
    assign pins_in[`PIN_TX] = addr3_tx_led_i; // RL3
    assign pins_in[`PIN_RX] = addr4_rx_led_i; // RL3

    // ----------------------------------------
    // Pin mode and address latch
    // ----------------------------------------
    // Sampling one clock after release keeps the async reset flops constant-loaded
    always_comb
    begin
        next_mode = mode;
        next_addr = addr;
        unique case (mode)
            ST_STRAP:
            begin
                next_mode = ST_CAPTURE;
            end
            ST_CAPTURE:
            begin
                next_addr = strap_addr(pins_in); // RL1 RL2 RL3
                next_mode = ST_LED;
            end
            ST_LED:
            begin
                // Soft reset has no path back to the strap states, so the latch holds
                next_mode = ST_LED; // RL10 RL12
                if (soft_reset)
                begin
                    // Pins stay outputs and the address is not taken again
                    next_mode = ST_LED; // RL10
                    next_addr = addr; // RL10
                end
            end
            default:
            begin
                // An unused state code parks the pins as outputs and keeps the latch
                next_mode = ST_LED;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mode <= ST_STRAP;
            addr <= `ADDR_RESET;
        end
        else
        begin
            mode <= next_mode;
            addr <= next_addr;
        end
    end

    // ----------------------------------------
    // Address output
    // ----------------------------------------
    assign phy_addr = addr; // RL12
    assign phy_addr_valid = (mode == ST_LED); // RL12

    // ----------------------------------------
    // Collision stretch
    // ----------------------------------------
    // Every collision reloads the hold time, so a burst keeps the LED lit
    collision_stretch #(
        .STRETCH_CYCLES(STRETCH_CYCLES)
    ) u_col (
        .clk(clk),
        .rstn(rstn),
        .collision(status.collision),
        .stretched(col_stretched)
    );

    // ----------------------------------------
    // LED drive
    // ----------------------------------------
    always_comb
    begin
        next_led_state = status_leds(status, col_stretched); // RL4 RL5 RL6 RL7 RL8 RL11
        next_drive.o = 5'h00;
        next_drive.oe_n = pin_enable_n(next_mode); // RL1 RL10
        // A soft reset leaves the pins driven as outputs
        if (next_mode == ST_LED)
        begin
            // An idle pin sits at the strap level, so the LED stays dark
            next_drive.o = pin_level(next_led_state, next_addr); // RL9
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            // Released pins during reset so the straps can be read
            drive.o <= 5'h00;
            drive.oe_n <= 5'h1f; // RL1
        end
        else
        begin
            drive <= next_drive;
        end
    end

    // ----------------------------------------
    // Pin fan-out
    // ----------------------------------------
    // Pin levels come straight from flops, so no status glitch reaches an LED
    assign addr0_activity_led_o = drive.o[`PIN_ACTIVITY];
    assign addr0_activity_led_oe_n = drive.oe_n[`PIN_ACTIVITY];
    assign addr1_collision_led_o = drive.o[`PIN_COLLISION];
    assign addr1_collision_led_oe_n = drive.oe_n[`PIN_COLLISION];
    assign addr2_link_led_o = drive.o[`PIN_LINK];
    assign addr2_link_led_oe_n = drive.oe_n[`PIN_LINK];
    assign addr3_tx_led_o = drive.o[`PIN_TX];
    assign addr3_tx_led_oe_n = drive.oe_n[`PIN_TX];
    assign addr4_rx_led_o = drive.o[`PIN_RX];
    assign addr4_rx_led_oe_n = drive.oe_n[`PIN_RX];

endmodule : strap_led

// >>> core/strap_led_cfg.svh
`ifndef STRAP_LED_CFG_SVH
`define STRAP_LED_CFG_SVH

// ----------------------------------------
// Pin positions within the strap bus
// ----------------------------------------
`define PIN_ACTIVITY 0
`define PIN_COLLISION 1
`define PIN_LINK 2
`define PIN_TX 3
`define PIN_RX 4

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 5
`define COL_STRETCH_MS 70
// Longest time rounds down
`define COL_STRETCH_CYCLES ((`COL_STRETCH_MS * 1000000) / `CLK_PERIOD_NS)

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ADDR_RESET 5'h00
`define STRETCH_RESET 24'h000000

`endif

// >>> core/strap_led_pkg.sv
package strap_led_pkg;

    typedef logic [4:0] phy_addr_t;

    typedef struct packed {
        logic collision;
        logic link;
        logic tx_active;
        logic rx_active;
    } link_status_s;

    typedef struct packed {
        logic [4:0] o;
        logic [4:0] oe_n;
    } pin_drive_s;

    typedef enum logic [1:0] {
        ST_STRAP,
        ST_CAPTURE,
        ST_LED
    } pin_mode_e;

endpackage : strap_led_pkg

// >>> dv/strap_led_chk.sv
`timescale 1ns/1ps
// ----
// Pin checks
// ----
module strap_led_chk
    import strap_led_pkg::*;
#(
    parameter int unsigned STRETCH_CYCLES = 20
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire link_status_s status,
    input wire logic addr0_activity_led_o,
    input wire logic addr1_collision_led_o,
    input wire logic addr2_link_led_o,
    input wire logic addr3_tx_led_o,
    input wire logic addr4_rx_led_o,
    input wire phy_addr_t phy_addr,
    input wire logic phy_addr_valid
);
    int unsigned idle;
    int unsigned next_idle;
    // Saturates past the stretch so a long quiet spell never wraps
    always_comb
        next_idle = status.collision ? 0 : idle + 32'(idle <= STRETCH_CYCLES + 1);
    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
            idle <= STRETCH_CYCLES + 2;
        else
            idle <= next_idle;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    addr_hold_a: assert property (phy_addr_valid |=> $stable(phy_addr))
        else $error("address moved");
    valid_hold_a: assert property (phy_addr_valid |=> phy_addr_valid)
        else $error("capture lost");
    link_led_a: assert property (
        phy_addr_valid |-> addr2_link_led_o == ($past(status.link) ^ phy_addr[2]))
        else $error("link led wrong");
    tx_led_a: assert property (
        phy_addr_valid |-> addr3_tx_led_o == ($past(status.tx_active) ^ phy_addr[3]))
        else $error("tx led wrong");
    rx_led_a: assert property (
        phy_addr_valid |-> addr4_rx_led_o == ($past(status.rx_active) ^ phy_addr[4]))
        else $error("rx led wrong");
    act_led_a: assert property (phy_addr_valid |-> addr0_activity_led_o ==
        ($past(status.tx_active | status.rx_active) ^ phy_addr[0]))
        else $error("activity led wrong");
    col_on_a: assert property (phy_addr_valid && $past(phy_addr_valid) &&
        idle inside {[1:STRETCH_CYCLES - 1]} |-> addr1_collision_led_o == !phy_addr[1])
        else $error("collision led dropped early");
    col_off_a: assert property (
        phy_addr_valid && idle > STRETCH_CYCLES + 1 |-> addr1_collision_led_o == phy_addr[1])
        else $error("collision led held too long");
endmodule : strap_led_chk
bind strap_led strap_led_chk #(.STRETCH_CYCLES(STRETCH_CYCLES)) chk_u (.clk, .rstn, .status,
    .addr0_activity_led_o, .addr1_collision_led_o, .addr2_link_led_o, .addr3_tx_led_o,
    .addr4_rx_led_o, .phy_addr, .phy_addr_valid);

// >>> dv/strap_pull.sv
`timescale 1ns/1ps
// ----
// Pull resistors with LEDs in series
// ----
module strap_pull
(
    input wire logic [4:0] strap,
    input wire logic [4:0] o,
    input wire logic [4:0] oe_n,
    output logic [4:0] pin,
    output logic [4:0] lit
);
    // A released pin falls to its pull level, never to a stale drive
    assign pin = (oe_n & strap) | (~oe_n & o);
    assign lit = ~oe_n & (o ^ strap);
endmodule : strap_pull

// >>> dv/tb_strap_led.sv
`timescale 1ns/1ps
// ----
// Strap capture and LED bench
// ----
module tb_strap_led
    import strap_led_pkg::*;
;
    localparam int unsigned S = 20;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic soft_reset = 1'b0;
    link_status_s status = '0;
    logic [4:0] strap = 5'h00;
    logic [4:0] pin, o, oe_n, lit;
    phy_addr_t phy_addr;
    logic phy_addr_valid;
    int errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    initial
        forever #2.5 clk = ~clk;
    strap_led #(.STRETCH_CYCLES(S)) dut_u (.clk, .rstn, .soft_reset, .status,
        .addr0_activity_led_i(pin[0]), .addr0_activity_led_o(o[0]),
        .addr0_activity_led_oe_n(oe_n[0]), .addr1_collision_led_i(pin[1]),
        .addr1_collision_led_o(o[1]), .addr1_collision_led_oe_n(oe_n[1]),
        .addr2_link_led_i(pin[2]), .addr2_link_led_o(o[2]), .addr2_link_led_oe_n(oe_n[2]),
        .addr3_tx_led_i(pin[3]), .addr3_tx_led_o(o[3]), .addr3_tx_led_oe_n(oe_n[3]),
        .addr4_rx_led_i(pin[4]), .addr4_rx_led_o(o[4]), .addr4_rx_led_oe_n(oe_n[4]),
        .phy_addr, .phy_addr_valid);
    strap_pull pull_u (.strap, .o, .oe_n, .pin, .lit);
    function automatic logic [4:0] exp_lit(input link_status_s s);
        return {s.rx_active, s.tx_active, s.link, s.collision, s.tx_active | s.rx_active};
    endfunction : exp_lit
    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim
    // Whole run is a few hundred cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            errors++;
            end_sim();
        end
    end
    initial
    begin
        void'($urandom(32'he0948cc1));
        for (int r = 0; r < 4; r++)
        begin
            @(negedge clk);
            rstn = 1'b0;
            status = '0;
            strap = (r == 0) ? 5'h00 : (r == 1) ? 5'h1f : 5'($urandom);
            repeat (2) @(negedge clk);
            rstn = 1'b1;
            @(negedge clk);
            chk(oe_n, 5'h1f);
            chk({4'h0, phy_addr_valid}, 5'h00);
            repeat (2) @(negedge clk);
            chk(phy_addr, strap);
            chk(oe_n, 5'h00);
            chk({4'h0, phy_addr_valid}, 5'h01);
            for (int i = 0; i < 20; i++)
            begin
                status = link_status_s'({1'b0, 3'($urandom)});
                soft_reset = 1'($urandom);
                @(negedge clk);
                chk(lit, exp_lit(status));
            end
            status = link_status_s'(4'h8);
            @(negedge clk);
            status = '0;
            repeat (S / 2) @(negedge clk);
            chk(lit, 5'h02);
            // A second collision restarts the hold time
            status = link_status_s'(4'h8);
            @(negedge clk);
            status = '0;
            repeat (S) @(negedge clk);
            chk(lit, 5'h02);
            @(negedge clk);
            chk(lit, 5'h00);
            chk(phy_addr, strap);
        end
        end_sim();
    end
endmodule : tb_strap_led
